// ===== verilog/msu_defines.vh
// Constant definitions shared by the serial channel design files.
`ifndef MSU_DEFINES_VH
`define MSU_DEFINES_VH

// ==========================================================================
// Oversampling and bit timing, in oversample ticks.
// ==========================================================================
`define MSU_OVS_W 5
`define MSU_TICKS_BIT 5'h10
`define MSU_TICKS_HALF 5'h08
`define MSU_TICKS_STOP1 6'h10
`define MSU_TICKS_STOP15 6'h18
`define MSU_TICKS_STOP2 6'h20
`define MSU_IDLE_TICKS 8'h40

// ==========================================================================
// Mode encodings.
// ==========================================================================
`define MSU_PAR_NONE 2'h0
`define MSU_PAR_ODD 2'h1
`define MSU_PAR_EVEN 2'h2
`define MSU_STOP_1 2'h0
`define MSU_STOP_15 2'h1
`define MSU_STOP_2 2'h2
`define MSU_LEN_BASE 4'h5

// ==========================================================================
// Interrupt cause positions.
// ==========================================================================
`define MSU_EV_RX_READY 0
`define MSU_EV_TX_EMPTY 1
`define MSU_EV_TX_DONE 2
`define MSU_EV_PARITY 3
`define MSU_EV_FRAMING 4
`define MSU_EV_OVERRUN 5
`define MSU_EV_BREAK 6
`define MSU_EV_CTS_CHG 7
`define MSU_EV_RX_IDLE 8
`define MSU_EV_TX_STALL 9
`define MSU_EV_COUNT 10

`endif

// ===== verilog/msu_tick_gen.v
// Oversample tick generator for the serial channel.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Divider: one pulse every (div_i + 1) clocks, sixteen pulses per bit.
// ==========================================================================
module msu_tick_gen #(
   parameter DIV_W = 16
) (
   input wire core_clk_i,
   input wire reset_n_i,
   input wire [DIV_W-1:0] div_i,
   output wire tick_o
);
   reg [DIV_W-1:0] cnt_r; // Counts down to the next tick.
   reg tick_r; // Registered tick keeps the pulse glitch free.

   assign tick_o = tick_r;

   // Reload on reaching zero; a new divisor takes effect at the next reload.
   always @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         cnt_r <= {DIV_W{1'b0}};
         tick_r <= 1'b0;
      end else if (cnt_r == {DIV_W{1'b0}}) begin
         cnt_r <= div_i;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// ===== verilog/msu_uart.v
// Full-duplex asynchronous serial channel with flow control and event causes.
// Behaviour
// - One channel; transmit and receive run independently.
// - Receiver assembles characters; transmitter serialises them.
// - Ten distinct event causes reported to software.
// - One receive line, one transmit line, crossed.
// - Programmable baud, parity, stop bits, length.
// - Transmit waits on clear-to-send; request-to-send follows capacity.
// - Clear-to-send and request-to-send are active low.
`timescale 1ns/1ps
`default_nettype none
`include "msu_defines.vh"

module msu_uart #(
   parameter DIV_W = 16,
   parameter DATA_W = 8
) (
   input wire core_clk_i,
   input wire reset_n_i,
   // Configuration.
   input wire [DIV_W-1:0] baud_div_i,
   input wire [1:0] parity_mode_i,
   input wire [1:0] stop_mode_i,
   input wire [1:0] char_len_i,
   input wire flow_en_i,
   // Processor transmit side.
   input wire [DATA_W-1:0] tx_data_i,
   input wire tx_valid_i,
   output wire tx_ready_o,
   // Processor receive side.
   output wire [DATA_W-1:0] rx_data_o,
   output wire rx_valid_o,
   input wire rx_ack_i,
   // Serial pins.
   input wire rxd_i,
   output wire txd_o,
   input wire cts_n_i,
   output wire rts_n_o,
   // Event causes, one-cycle pulses.
   output wire [`MSU_EV_COUNT-1:0] event_o
);
   // ======================================================================
   // States, shared by both directions.
   // ======================================================================
   localparam ST_IDLE = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_PAR = 3'h3;
   localparam ST_STOP = 3'h4;

   // Parity bit for a data word under the given mode.
   function par_bit;
      input [DATA_W-1:0] d;
      input [1:0] mode;
      begin
         par_bit = (mode == `MSU_PAR_ODD) ? ~(^d) : (^d);
      end
   endfunction

   // Mask of valid data bits for the configured character length.
   function [DATA_W-1:0] len_mask;
      input [1:0] len;
      begin
         len_mask = ~({DATA_W{1'b1}} << (len + `MSU_LEN_BASE));
      end
   endfunction

   wire tick; // Oversample tick, sixteen per bit.
   wire [3:0] nbits; // Data bits per character.
   wire par_en; // Parity bit present.
   reg [5:0] stop_ticks; // Stop length in ticks.
   reg [`MSU_EV_COUNT-1:0] ev_r; // Registered event pulses.
   reg [`MSU_EV_COUNT-1:0] ev_nxt;

   assign nbits = {2'h0, char_len_i} + `MSU_LEN_BASE;
   assign par_en = (parity_mode_i == `MSU_PAR_ODD) || (parity_mode_i == `MSU_PAR_EVEN);
   assign event_o = ev_r;

   // Stop-bit length selection; half a bit is eight oversample ticks.
   always @* begin
      if (stop_mode_i == `MSU_STOP_15) begin
         stop_ticks = `MSU_TICKS_STOP15;
      end else if (stop_mode_i == `MSU_STOP_2) begin
         stop_ticks = `MSU_TICKS_STOP2;
      end else begin
         stop_ticks = `MSU_TICKS_STOP1;
      end
   end

   msu_tick_gen #(
      .DIV_W(DIV_W)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .div_i(baud_div_i),
      .tick_o(tick)
   );

   // ======================================================================
   // Transmitter.
   // ======================================================================
   reg [2:0] tx_st_r; // Transmit state.
   reg [DATA_W-1:0] tx_hold_r; // Holding register written by the processor.
   reg tx_full_r; // Holding register occupied.
   reg [DATA_W-1:0] tx_sh_r; // Shift register.
   reg [3:0] tx_bit_r; // Data bits sent so far.
   reg [5:0] tx_tk_r; // Ticks within the current bit.
   reg txd_r; // Line level, idles high.
   reg tx_par_r; // Parity of the character in flight.
   reg cts_q_r; // Previous clear-to-send level for change detection.
   reg stall_seen_r; // Stops the stall event repeating every cycle.
   wire cts_ok; // Transmit may begin.
   wire tx_load;

   assign cts_ok = !flow_en_i || !cts_n_i;
   assign tx_ready_o = !tx_full_r;
   assign txd_o = txd_r;
   assign tx_load = (tx_st_r == ST_IDLE) && tx_full_r && cts_ok;

   // The CTS check is made only between characters, so a character once
   // started always completes; stopping mid-frame would corrupt it.
   always @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         tx_st_r <= ST_IDLE;
         tx_hold_r <= {DATA_W{1'b0}};
         tx_full_r <= 1'b0;
         tx_sh_r <= {DATA_W{1'b0}};
         tx_bit_r <= 4'h0;
         tx_tk_r <= 6'h00;
         txd_r <= 1'b1;
         tx_par_r <= 1'b0;
      end else begin
         if (tx_valid_i && !tx_full_r) begin
            tx_hold_r <= tx_data_i;
            tx_full_r <= 1'b1;
         end
         case (tx_st_r)
            ST_IDLE: begin
               txd_r <= 1'b1;
               if (tx_load) begin
                  tx_sh_r <= tx_hold_r & len_mask(char_len_i);
                  tx_par_r <= par_bit(tx_hold_r & len_mask(char_len_i), parity_mode_i);
                  tx_full_r <= 1'b0;
                  tx_st_r <= ST_START;
                  tx_tk_r <= 6'h00;
                  txd_r <= 1'b0;
               end
            end
            ST_START, ST_DATA, ST_PAR: begin
               if (tick) begin
                  if (tx_tk_r == {1'b0, `MSU_TICKS_BIT} - 6'h01) begin
                     tx_tk_r <= 6'h00;
                     if (tx_st_r != ST_DATA || tx_bit_r != nbits) begin
                        // Next bit to send, LSB first.
                        if (tx_st_r != ST_PAR && tx_bit_r != nbits) begin
                           txd_r <= tx_sh_r[0];
                           tx_sh_r <= tx_sh_r >> 1;
                           tx_bit_r <= tx_bit_r + 4'h1;
                           tx_st_r <= ST_DATA;
                        end else begin
                           txd_r <= 1'b1;
                           tx_st_r <= ST_STOP;
                        end
                     end else if (par_en) begin
                        txd_r <= tx_par_r;
                        tx_st_r <= ST_PAR;
                     end else begin
                        txd_r <= 1'b1;
                        tx_st_r <= ST_STOP;
                     end
                  end else begin
                     tx_tk_r <= tx_tk_r + 6'h01;
                  end
               end
            end
            ST_STOP: begin
               if (tick) begin
                  if (tx_tk_r == stop_ticks - 6'h01) begin
                     tx_st_r <= ST_IDLE;
                     tx_bit_r <= 4'h0;
                     tx_tk_r <= 6'h00;
                  end else begin
                     tx_tk_r <= tx_tk_r + 6'h01;
                  end
               end
            end
            default: begin
               tx_st_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ======================================================================
   // Receiver.
   // ======================================================================
   reg [2:0] rx_st_r; // Receive state.
   reg [DATA_W-1:0] rx_sh_r; // Assembly register.
   reg [DATA_W-1:0] rx_data_r; // Completed character for the processor.
   reg rx_full_r; // Completed character not yet taken.
   reg [3:0] rx_bit_r; // Data bits received.
   reg [5:0] rx_tk_r; // Ticks within the current bit.
   reg rx_par_r; // Received parity bit.
   reg [7:0] idle_r; // Idle-line tick count after a character.
   reg idle_arm_r; // A character arrived since the last idle event.

   assign rx_data_o = rx_data_r;
   assign rx_valid_o = rx_full_r;
   // Request-to-send goes high (stop) while the single slot is occupied,
   // which gives no margin: a sender that ignores it overruns.
   assign rts_n_o = flow_en_i ? rx_full_r : 1'b0;

   // Samples at the middle of each bit; the start bit is confirmed at its
   // middle so that short glitches are not taken as characters.
   always @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         rx_st_r <= ST_IDLE;
         rx_sh_r <= {DATA_W{1'b0}};
         rx_data_r <= {DATA_W{1'b0}};
         rx_full_r <= 1'b0;
         rx_bit_r <= 4'h0;
         rx_tk_r <= 6'h00;
         rx_par_r <= 1'b0;
         ev_r <= {`MSU_EV_COUNT{1'b0}};
         cts_q_r <= cts_n_i; // Follows the pin so release shows no false change.
         stall_seen_r <= 1'b0;
         idle_r <= 8'h00;
         idle_arm_r <= 1'b0;
      end else begin
         ev_r <= ev_nxt;
         cts_q_r <= cts_n_i;
         stall_seen_r <= (tx_st_r == ST_IDLE) && tx_full_r && !cts_ok;
         if (rx_ack_i) begin
            rx_full_r <= 1'b0;
         end
         if (rx_st_r != ST_IDLE || !rxd_i) begin
            idle_r <= 8'h00;
         end else if (tick && idle_r != `MSU_IDLE_TICKS) begin
            idle_r <= idle_r + 8'h01;
         end
         if (ev_nxt[`MSU_EV_RX_IDLE]) begin
            idle_arm_r <= 1'b0;
         end
         case (rx_st_r)
            ST_IDLE: begin
               rx_bit_r <= 4'h0;
               rx_tk_r <= 6'h00;
               rx_par_r <= 1'b0; // A stale parity bit must not mask a later break.
               if (!rxd_i) begin
                  rx_st_r <= ST_START;
               end
            end
            default: begin
               if (tick) begin
                  rx_tk_r <= rx_tk_r + 6'h01;
                  if (rx_st_r == ST_START && rx_tk_r == {1'b0, `MSU_TICKS_HALF} - 6'h01) begin
                     rx_tk_r <= 6'h00;
                     rx_st_r <= rxd_i ? ST_IDLE : ST_DATA;
                  end else if (rx_st_r != ST_START &&
                               rx_tk_r == {1'b0, `MSU_TICKS_BIT} - 6'h01) begin
                     rx_tk_r <= 6'h00;
                     if (rx_st_r == ST_DATA) begin
                        rx_sh_r <= {rxd_i, rx_sh_r[DATA_W-1:1]};
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == nbits - 4'h1) begin
                           rx_st_r <= par_en ? ST_PAR : ST_STOP;
                        end
                     end else if (rx_st_r == ST_PAR) begin
                        rx_par_r <= rxd_i;
                        rx_st_r <= ST_STOP;
                     end else begin
                        // Stop bit sampled; character complete.
                        rx_st_r <= ST_IDLE;
                        rx_data_r <= rx_sh_r >> (DATA_W[3:0] - nbits);
                        rx_full_r <= 1'b1;
                        idle_arm_r <= 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // ======================================================================
   // Event causes.
   // ======================================================================
   wire rx_done;
   wire [DATA_W-1:0] rx_word;

   assign rx_done = tick && rx_st_r == ST_STOP && rx_tk_r == {1'b0, `MSU_TICKS_BIT} - 6'h01;
   assign rx_word = rx_sh_r >> (DATA_W[3:0] - nbits);

   // Each cause is a one-cycle pulse; they are not sticky here.
   always @* begin
      ev_nxt = {`MSU_EV_COUNT{1'b0}};
      ev_nxt[`MSU_EV_RX_READY] = rx_done;
      ev_nxt[`MSU_EV_TX_EMPTY] = tx_load;
      ev_nxt[`MSU_EV_TX_DONE] = tick && tx_st_r == ST_STOP && tx_tk_r == stop_ticks - 6'h01;
      ev_nxt[`MSU_EV_PARITY] = rx_done && par_en &&
                               (rx_par_r != par_bit(rx_word, parity_mode_i));
      ev_nxt[`MSU_EV_FRAMING] = rx_done && !rxd_i;
      ev_nxt[`MSU_EV_OVERRUN] = rx_done && rx_full_r && !rx_ack_i;
      ev_nxt[`MSU_EV_BREAK] = rx_done && !rxd_i && rx_word == {DATA_W{1'b0}} && !rx_par_r;
      ev_nxt[`MSU_EV_CTS_CHG] = cts_q_r != cts_n_i;
      ev_nxt[`MSU_EV_RX_IDLE] = idle_arm_r && tick && idle_r == `MSU_IDLE_TICKS - 8'h01;
      ev_nxt[`MSU_EV_TX_STALL] = (tx_st_r == ST_IDLE) && tx_full_r && !cts_ok && !stall_seen_r;
   end
endmodule

`default_nettype wire

// ===== verilog/unused_placeholder_note.v
// Intentionally empty compilation unit kept out of the build.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/msu_uart_properties.sv
// Concurrent checks on the ports of the serial channel.
`timescale 1ns/1ps
`default_nettype none
`include "msu_defines.vh"

// ==========================================================================
// Checker module.
// ==========================================================================
module msu_uart_properties #(
   parameter DATA_W = 8
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic flow_en_i,
   input wire logic tx_valid_i,
   input wire logic tx_ready_o,
   input wire logic [DATA_W-1:0] rx_data_o,
   input wire logic rx_valid_o,
   input wire logic rx_ack_i,
   input wire logic txd_o,
   input wire logic cts_n_i,
   input wire logic rts_n_o,
   input wire logic [`MSU_EV_COUNT-1:0] event_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // An accepted write, and a held character that nobody has acknowledged.
   sequence s_take;
      tx_valid_i && tx_ready_o;
   endsequence
   sequence s_full;
      rx_valid_o && !rx_ack_i;
   endsequence

   a_take_drops_ready: assert property (s_take |=> !tx_ready_o)
      else $error("holding register still ready after a write");
   a_rx_held_stable: assert property (s_full |=> rx_valid_o && (event_o[0] || $stable(rx_data_o)))
      else $error("received character lost before acknowledge");
   a_ack_clears_full: assert property (rx_valid_o && rx_ack_i |=> !rx_valid_o || event_o[0])
      else $error("acknowledge did not empty the receive slot");
   a_rx_ready_event: assert property ($rose(rx_valid_o) |-> event_o[0])
      else $error("new character without its event");
   a_err_with_char: assert property ((|event_o[6:3]) |-> event_o[0] && rx_valid_o)
      else $error("receive fault event without a character");
   a_break_all_zero: assert property (event_o[6] |-> event_o[4] && rx_data_o == 0)
      else $error("break reported on a nonzero character");
   a_rts_tracks_full: assert property (rts_n_o == (flow_en_i && rx_valid_o))
      else $error("request-to-send does not follow the receive slot");
   a_stall_needs_cts: assert property (event_o[9] |-> flow_en_i && ($past(cts_n_i) || $past(cts_n_i, 2)))
      else $error("stall event while clear-to-send was asserted");
   a_done_stop_high: assert property (event_o[2] |-> txd_o && $past(txd_o, 8))
      else $error("transmit done without a high stop bit");
   a_overrun_full: assert property (event_o[5] |-> $past(rx_valid_o) && rx_valid_o)
      else $error("overrun reported on an empty slot");
endmodule

bind msu_uart msu_uart_properties #(.DATA_W(DATA_W)) u_props (
   .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .flow_en_i(flow_en_i),
   .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
   .rx_valid_o(rx_valid_o), .rx_ack_i(rx_ack_i), .txd_o(txd_o), .cts_n_i(cts_n_i),
   .rts_n_o(rts_n_o), .event_o(event_o)
);
`default_nettype wire

// ===== tb/msu_peer.sv
// Behavioural serial device on the far side of the channel.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Peer: sends on rxd_o, listens on txd_i, drives clear-to-send.
// ==========================================================================
module msu_peer #(
   parameter int BIT = 16
) (
   input wire logic core_clk_i,
   input wire logic txd_i,
   output logic rxd_o,
   output logic cts_n_o
);
   initial begin
      rxd_o = 1'b1; // Idle line is high.
      cts_n_o = 1'b0; // Low means clear to send.
   end

   // Holds one bit for a whole bit time, starting just after an edge.
   task automatic bit_out(input logic b);
      rxd_o = b;
      repeat (BIT) @(posedge core_clk_i);
      #1;
   endtask

   // Sends one character; bad_par flips parity, stop low makes a framing fault.
   task automatic send(input logic [7:0] d, input int n, input logic [1:0] par,
                       input logic bad_par, input logic stop);
      logic p;
      p = ^(d & ((8'h01 << n) - 8'h01)) ^ (par == 2'h1) ^ bad_par;
      bit_out(1'b0);
      for (int i = 0; i < n; i++) bit_out(d[i]);
      if (par == 2'h1 || par == 2'h2) bit_out(p);
      bit_out(stop);
      if (!stop) rxd_o = 1'b1; // A high stop bit already leaves the line idle.
   endtask

   // Receives one character, sampling mid-bit on the falling clock edge.
   task automatic recv(output logic [7:0] d, output logic p, output logic stp,
                       input int n, input logic par);
      int k;
      d = 8'h00;
      p = 1'b0;
      stp = 1'b0;
      k = 0;
      while (txd_i !== 1'b0 && k < 4000) begin
         @(negedge core_clk_i);
         k++;
      end
      repeat (BIT / 2) @(negedge core_clk_i);
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(negedge core_clk_i);
         d[i] = txd_i;
      end
      if (par) begin
         repeat (BIT) @(negedge core_clk_i);
         p = txd_i;
      end
      repeat (BIT) @(negedge core_clk_i);
      stp = (k < 4000) ? txd_i : 1'b0;
   endtask

   // Changes clear-to-send just after an edge.
   task automatic set_cts(input logic v);
      cts_n_o = v;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench for the serial channel.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [15:0] baud_div_i = 16'h0000; // Sixteen clocks per bit keeps runs short.
   logic [1:0] parity_mode_i = 2'h0;
   logic [1:0] stop_mode_i = 2'h0;
   logic [1:0] char_len_i = 2'h3;
   logic flow_en_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic tx_valid_i = 1'b0;
   logic rx_ack_i = 1'b0;
   logic ev_clr = 1'b0;
   logic [9:0] ev_seen = 10'h000; // Sticky copy of event pulses.
   wire tx_ready_o, rx_valid_o, txd_o, rts_n_o, rxd_i, cts_n_i;
   wire [7:0] rx_data_o;
   wire [9:0] event_o;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   msu_uart u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .baud_div_i(baud_div_i),
      .parity_mode_i(parity_mode_i), .stop_mode_i(stop_mode_i), .char_len_i(char_len_i),
      .flow_en_i(flow_en_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
      .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
      .rx_ack_i(rx_ack_i), .rxd_i(rxd_i), .txd_o(txd_o), .cts_n_i(cts_n_i),
      .rts_n_o(rts_n_o), .event_o(event_o));
   msu_peer u_peer (.core_clk_i(core_clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i));

   initial forever #2 core_clk_i = ~core_clk_i;

   // Gathers event pulses and cuts a hang short.
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      ev_seen <= ev_clr ? event_o : (ev_seen | event_o);
      if (cycles == 60000) begin
         errors++;
         summarize();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic clr();
      ev_clr = 1'b1;
      step(1);
      ev_clr = 1'b0;
   endtask

   // Holds the write until the edge where ready is high, then drops it.
   task automatic put(input logic [7:0] d);
      int k;
      tx_valid_i = 1'b1;
      tx_data_i = d;
      k = 0;
      while (tx_ready_o !== 1'b1 && k < 4000) begin
         step(1);
         k++;
      end
      step(1);
      tx_valid_i = 1'b0;
   endtask

   task automatic wait_rx();
      int k;
      k = 0;
      while (rx_valid_o !== 1'b1 && k < 400) begin
         step(1);
         k++;
      end
   endtask

   task automatic ack();
      rx_ack_i = 1'b1;
      step(1);
      rx_ack_i = 1'b0;
   endtask

   // Waits for the serial output to reach a level and notes the cycle.
   task automatic at_level(input logic lvl, output int t);
      int k;
      k = 0;
      while (txd_o !== lvl && k < 4000) begin
         @(negedge core_clk_i);
         k++;
      end
      t = cycles;
   endtask

   // Every length and parity mode, in both directions.
   task automatic t_formats();
      logic [7:0] d, m, rd;
      logic rp, rs;
      for (int l = 0; l < 4; l++) begin
         for (int p = 0; p < 3; p++) begin
            char_len_i = l[1:0];
            parity_mode_i = p[1:0];
            d = 8'h96 ^ {l[1:0], p[1:0], 4'h3};
            m = (8'h01 << (5 + l)) - 8'h01;
            clr();
            put(d);
            u_peer.recv(rd, rp, rs, 5 + l, p != 0);
            check(rd, d & m);
            if (p != 0) check(rp, ^(d & m) ^ (p == 1));
            check(rs, 1'b1);
            step(30);
            check(ev_seen[2:1], 2'h3);
            u_peer.send(~d, 5 + l, p[1:0], 1'b0, 1'b1);
            wait_rx();
            check(rx_data_o, ~d & m);
            check({ev_seen[3], ev_seen[0]}, 2'h1);
            ack();
         end
      end
   endtask

   // Stop length: start bit spacing grows by 8 and 16 clocks; mode 3 acts as one.
   task automatic t_stop();
      int t0, t1, t2, gap0;
      char_len_i = 2'h3;
      parity_mode_i = 2'h0;
      for (int s = 0; s < 4; s++) begin
         stop_mode_i = s[1:0];
         step(300);
         fork
            begin
               put(8'hff);
               step(1);
               put(8'hff);
            end
            begin
               at_level(1'b0, t0);
               at_level(1'b1, t1);
               at_level(1'b0, t2);
            end
         join
         check(t1 - t0, 16);
         if (s == 0) gap0 = t2 - t0;
         check(t2 - t0 - gap0, (s == 3) ? 0 : 8 * s);
      end
      stop_mode_i = 2'h0;
      step(400);
   endtask

   // Parity and framing faults, break and overrun on the receive side.
   task automatic t_faults();
      parity_mode_i = 2'h2;
      clr();
      u_peer.send(8'h3c, 8, 2'h2, 1'b1, 1'b1);
      wait_rx();
      check(ev_seen[3], 1'b1);
      ack();
      parity_mode_i = 2'h0;
      clr();
      u_peer.send(8'h55, 8, 2'h0, 1'b0, 1'b0);
      wait_rx();
      check(ev_seen[4], 1'b1);
      ack();
      step(40);
      clr();
      u_peer.send(8'h00, 8, 2'h0, 1'b0, 1'b0);
      wait_rx();
      check(ev_seen[6], 1'b1);
      ack();
      step(40);
      clr();
      u_peer.send(8'h11, 8, 2'h0, 1'b0, 1'b1);
      u_peer.send(8'h22, 8, 2'h0, 1'b0, 1'b1);
      step(30);
      check({ev_seen[5], rx_data_o}, {1'b1, 8'h22});
      ack();
      step(60);
      check(ev_seen[8], 1'b1);
   endtask

   // Flow control: request-to-send tracks the slot, clear-to-send holds transmit.
   task automatic t_flow();
      logic [7:0] rd;
      logic rp, rs;
      int lows;
      flow_en_i = 1'b1;
      step(1);
      check(rts_n_o, 1'b0);
      u_peer.send(8'h5a, 8, 2'h0, 1'b0, 1'b1);
      wait_rx();
      check(rts_n_o, 1'b1);
      ack();
      check(rts_n_o, 1'b0);
      u_peer.set_cts(1'b1);
      clr();
      put(8'h81);
      lows = 0;
      repeat (200) begin
         step(1);
         if (txd_o !== 1'b1) lows++;
      end
      check(lows, 0);
      check(ev_seen[9], 1'b1);
      check(ev_seen[7], 1'b1);
      u_peer.set_cts(1'b0);
      u_peer.recv(rd, rp, rs, 8, 1'b0);
      check(rd, 8'h81);
      flow_en_i = 1'b0;
      step(40);
   endtask

   // Both directions at once.
   task automatic t_duplex();
      logic [7:0] rd;
      logic rp, rs;
      fork
         u_peer.send(8'hc3, 8, 2'h0, 1'b0, 1'b1);
         begin
            put(8'h3c);
            u_peer.recv(rd, rp, rs, 8, 1'b0);
         end
      join
      wait_rx();
      check({rd, rx_data_o}, 16'h3cc3);
      ack();
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Reset for two cycles, then run every scenario.
   initial begin
      step(2);
      reset_n_i = 1'b1;
      check({txd_o, tx_ready_o, rx_valid_o, event_o}, 13'h1800);
      check($bits(event_o), 10);
      t_formats();
      t_stop();
      t_faults();
      t_flow();
      t_duplex();
      summarize();
   end
endmodule
`default_nettype wire
